// ===== hdl/charger_detect_top.sv
// upstream charger detection, charger-detect output and register slave
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module charger_detect_top import chgdet_pkg::*; #(
  parameter int NUM_PORTS = 4
) (
  input  wire logic                 sys_clk,          // 200 mhz clock
  input  wire logic                 reset_n,          // sync reset, low
  input  wire logic                 s_axi_awvalid,    // write addr valid
  output logic                      s_axi_awready,    // write addr ready
  input  wire logic [7:0]           s_axi_awaddr,     // write byte addr
  input  wire logic                 s_axi_wvalid,     // write data valid
  output logic                      s_axi_wready,     // write data ready
  input  wire logic [31:0]          s_axi_wdata,      // write data
  input  wire logic [3:0]           s_axi_wstrb,      // byte enables
  output logic                      s_axi_bvalid,     // write resp valid
  input  wire logic                 s_axi_bready,     // write resp ready
  output logic      [1:0]           s_axi_bresp,      // write response
  input  wire logic                 s_axi_arvalid,    // read addr valid
  output logic                      s_axi_arready,    // read addr ready
  input  wire logic [7:0]           s_axi_araddr,     // read byte addr
  output logic                      s_axi_rvalid,     // read data valid
  input  wire logic                 s_axi_rready,     // read data ready
  output logic      [31:0]          s_axi_rdata,      // read data
  output logic      [1:0]           s_axi_rresp,      // read response
  input  wire logic                 detection_stage,  // hub in detect
  input  wire logic                 clock_wait_stage, // hub awaits clk
  input  wire logic                 reference_clock_input, // sampled
  input  wire logic                 upstream_hsic,    // upstream is hsic
  input  wire logic                 vbus_present,     // bus power seen
  input  wire logic                 device_suspended, // usb suspend
  input  wire logic                 device_configured, // set config
  input  wire logic                 line_short,       // lines shorted
  input  wire logic                 dm_reflect,       // dp seen on dm
  input  wire logic                 dp_low,           // dp pulled down
  input  wire logic                 dm_low,           // dm pulled down
  input  wire logic                 dp_2v0,           // dp at 2.0 v
  input  wire logic                 dp_2v7,           // dp at 2.7 v
  input  wire logic                 dm_2v0,           // dm at 2.0 v
  input  wire logic                 dm_2v7,           // dm at 2.7 v
  output logic                      dp_src_en,        // source on dp
  output logic                      dm_src_en,        // source on dm
  output logic                      dm_sink_en,       // sink on dm
  output logic      [1:0]           charger_detect_out, // to pmic
  output logic                      irq,              // level interrupt
  output logic                      downstream_supply_indicator, // ext
  input  wire logic [NUM_PORTS-1:0] bc_query,         // device queries
  input  wire logic [NUM_PORTS-1:0] downstream_hsic,  // port is hsic
  output logic      [NUM_PORTS-1:0] bc_ack            // query answered
);

  localparam int CW = $clog2(SETTLE_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(SETTLE_CYC - 1);

  typedef struct packed {
    det_state_type          state;
    logic [CW-1:0]          cnt;
    logic [2:0]             chg_type;
    logic                   chg_hit;
    logic                   done;
    logic                   go_d;
    logic                   ref_d;
    logic                   ref_seen;
    logic [1:0]             evt_d;
    logic [7:0]             ctrl;
    logic [7:0]             mask;
    logic [3:0]             man;
    logic [3:0]             sts;
    logic [3:0]             msk;
    logic [NUM_PORTS-1:0]   bcen;
    logic [NUM_PORTS-1:0]   ack;
    logic [1:0]             out;
    logic                   aw_got;
    logic [7:0]             awaddr;
    logic                   w_got;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
  } top_type;

  top_type    st_r;
  top_type    st_nxt;
  logic [2:0] cls_code;
  logic       go_lvl;
  logic       start;
  logic       auto_drive;
  logic [1:0] out_code;

  line_classifier u_cls (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .line_short (line_short),
    .dm_reflect (dm_reflect),
    .dp_low     (dp_low),
    .dm_low     (dm_low),
    .dp_2v0     (dp_2v0),
    .dp_2v7     (dp_2v7),
    .dm_2v0     (dm_2v0),
    .dm_2v7     (dm_2v7),
    .enhanced   (st_r.ctrl[CTRL_ENH_BIT]),
    .code_r     (cls_code)
  );

  // byte-lane merge of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // stage entry; in clock wait, reference_clock_input activity or the oscillator fallback
  assign go_lvl = st_r.ctrl[CTRL_DET_EN_BIT] && !upstream_hsic &&
                  (detection_stage ||
                   (clock_wait_stage &&
                    (st_r.ctrl[CTRL_OSC_BIT] || st_r.ref_seen)));
  assign start  = go_lvl && !st_r.go_d;

  // selected output code before per-bit enables
  always_comb begin
    out_code = OUT_NONE;
    if (st_r.ctrl[CTRL_EVTSEL_BIT] && vbus_present) begin
      out_code = (device_configured && !device_suspended) ?
                 OUT_CFG : OUT_VBUS;
    end
    if (st_r.ctrl[CTRL_CHGSEL_BIT] && st_r.chg_hit) begin
      out_code = OUT_CHG;
    end
  end

  always_comb begin
    logic [31:0] img;
    logic [3:0]  set_ev;
    logic [3:0]  clr_ev;
    img    = '0;
    set_ev = '0;
    clr_ev = '0;
    st_nxt = st_r;
    st_nxt.go_d  = go_lvl;
    st_nxt.ref_d = reference_clock_input;
    if (st_r.ref_d != reference_clock_input) begin
      st_nxt.ref_seen = 1'b1;
    end

    // detection sequence
    unique case (st_r.state)
      DET_IDLE, DET_DONE: begin
        if (start) begin
          st_nxt.state    = DET_PROBE;
          st_nxt.cnt      = '0;
          st_nxt.chg_hit  = 1'b0;
          st_nxt.chg_type = TYPE_NONE;
          st_nxt.done     = 1'b0;
        end
      end
      DET_PROBE: begin
        st_nxt.cnt = st_r.cnt + 1'b1;
        if (st_r.cnt == CNT_LAST) begin
          st_nxt.state = DET_SAMPLE;
        end
      end
      DET_SAMPLE: begin
        st_nxt.state    = DET_DONE;
        st_nxt.chg_type = cls_code;
        st_nxt.chg_hit  = st_r.mask[cls_code];
        st_nxt.done     = 1'b1;
        set_ev[IRQ_DONE_BIT] = 1'b1;
      end
    endcase
    // an hsic upstream port abandons any run in flight
    if (upstream_hsic) begin
      st_nxt.state = DET_IDLE;
    end

    // output code and device events
    st_nxt.out = out_code & st_r.ctrl[CTRL_OUTEN_LSB +: 2];
    if (st_nxt.out != st_r.out) begin
      set_ev[IRQ_CHG_BIT] = 1'b1;
    end
    st_nxt.evt_d = {device_configured, device_suspended};
    set_ev[IRQ_SUSP_BIT] = device_suspended && !st_r.evt_d[0];
    set_ev[IRQ_CFG_BIT]  = device_configured && !st_r.evt_d[1];

    // downstream charging query, answered one cycle later for as long as it is held
    st_nxt.ack = bc_query & st_r.bcen & ~downstream_hsic;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      unique case (st_r.awaddr)
        CTRL_OFS: begin
          img = merge({24'h000000, st_r.ctrl}, st_r.wdata, st_r.wstrb);
          st_nxt.ctrl = img[7:0];
        end
        MASK_OFS: begin
          img = merge({24'h000000, st_r.mask}, st_r.wdata, st_r.wstrb);
          st_nxt.mask = img[7:0];
        end
        ISTS_OFS: begin
          clr_ev = st_r.wstrb[0] ? st_r.wdata[3:0] : 4'h0;
        end
        IMSK_OFS: begin
          img = merge({28'h0000000, st_r.msk}, st_r.wdata, st_r.wstrb);
          st_nxt.msk = img[3:0];
        end
        MAN_OFS: begin
          img = merge({28'h0000000, st_r.man}, st_r.wdata, st_r.wstrb);
          st_nxt.man = img[3:0];
        end
        BCEN_OFS: begin
          img = merge(32'(st_r.bcen), st_r.wdata, st_r.wstrb);
          st_nxt.bcen = img[NUM_PORTS-1:0];
        end
        STAT_OFS: ; // read-only, write ignored
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // a new event wins over a clear in the same cycle
    st_nxt.sts = (st_r.sts & ~clr_ev) | set_ev;

    // read channel, data captured at the address handshake
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      st_nxt.rdata  = '0;
      unique case (s_axi_araddr)
        CTRL_OFS: st_nxt.rdata[7:0] = st_r.ctrl;
        MASK_OFS: st_nxt.rdata[7:0] = st_r.mask;
        STAT_OFS: st_nxt.rdata[17:0] = {dm_2v7, dm_2v0, dp_2v7, dp_2v0,
                                        dm_low, dp_low, dm_reflect,
                                        line_short, 1'b0, st_r.out,
                                        st_r.done, st_r.state,
                                        st_r.chg_hit, st_r.chg_type};
        ISTS_OFS: st_nxt.rdata[3:0] = st_r.sts;
        IMSK_OFS: st_nxt.rdata[3:0] = st_r.msk;
        MAN_OFS:  st_nxt.rdata[3:0] = st_r.man;
        BCEN_OFS: st_nxt.rdata[NUM_PORTS-1:0] = st_r.bcen;
        default:  st_nxt.rresp = RESP_SLVERR;
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // single state register; control reaches reset values here
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r       <= '0;
      st_r.state <= DET_IDLE;
      st_r.ctrl  <= CTRL_RST;
      st_r.mask  <= MASK_RST;
      st_r.msk   <= IMSK_RST;
      st_r.man   <= MAN_RST;
      st_r.ref_d <= reference_clock_input; // no false reference_clock_input edge at release
    end else begin
      st_r <= st_nxt;
    end
  end

  // bus handshakes; one write and one read outstanding at most
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;

  // manual override is never gated by stage, software owns that hazard
  assign auto_drive = (st_r.state == DET_PROBE) ||
                      (st_r.state == DET_SAMPLE);
  assign dp_src_en  = st_r.man[MAN_OVR_BIT] ? st_r.man[MAN_DPSRC_BIT] :
                      auto_drive;
  assign dm_src_en  = st_r.man[MAN_OVR_BIT] && st_r.man[MAN_DMSRC_BIT];
  assign dm_sink_en = st_r.man[MAN_OVR_BIT] ? st_r.man[MAN_DMSINK_BIT] :
                      auto_drive;

  assign charger_detect_out = st_r.out;
  assign irq = |(st_r.sts & st_r.msk);
  assign downstream_supply_indicator = st_r.ctrl[CTRL_SUP_BIT];
  assign bc_ack = st_r.ack;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_stage_entry;
    start && (st_r.state == DET_IDLE || st_r.state == DET_DONE);
  endsequence
  sequence s_probe_end;
    st_r.state == DET_PROBE && st_r.cnt == CNT_LAST;
  endsequence

  a_auto_start: assert property (
    s_stage_entry ##0 !upstream_hsic |=> st_r.state == DET_PROBE)
    else $error("detection did not start on stage entry");
  a_probe_sample: assert property (
    s_probe_end ##0 !upstream_hsic |=> st_r.state == DET_SAMPLE
      ##1 st_r.done && st_r.chg_type == $past(cls_code))
    else $error("probe did not end in a sampled type");
  a_manual_drive: assert property (
    st_r.man[MAN_OVR_BIT] |-> dp_src_en == st_r.man[MAN_DPSRC_BIT] &&
                              dm_sink_en == st_r.man[MAN_DMSINK_BIT])
    else $error("manual driver setting not honoured");
  a_mask_gate: assert property (
    st_r.state == DET_SAMPLE && !upstream_hsic |=>
      st_r.chg_hit == $past(st_r.mask[cls_code]))
    else $error("type mask not applied to charger hit");
  a_hsic_block: assert property (
    upstream_hsic |=> st_r.state == DET_IDLE && !dp_src_en ||
                      st_r.man[MAN_OVR_BIT])
    else $error("detection ran with hsic upstream");
  a_code_charger: assert property (
    st_r.chg_hit && st_r.ctrl[CTRL_CHGSEL_BIT] &&
    st_r.ctrl[CTRL_OUTEN_LSB +: 2] == 2'h3 |=> charger_detect_out == OUT_CHG)
    else $error("charger hit not shown as code 11");
  a_bit_enable: assert property (
    !st_r.ctrl[CTRL_OUTEN_LSB] |=> !charger_detect_out[0])
    else $error("disabled output bit driven high");
  a_done_irq: assert property (
    st_r.state == DET_SAMPLE && !upstream_hsic |=>
      st_r.sts[IRQ_DONE_BIT] && (!st_r.msk[IRQ_DONE_BIT] || irq))
    else $error("detection done not flagged");
  a_reset_quiet: assert property (
    $rose(reset_n) |-> charger_detect_out == OUT_NONE && !irq)
    else $error("output or interrupt active after reset");
  a_query_ack: assert property (
    bc_ack[0] |-> $past(bc_query[0]) && !$past(downstream_hsic[0]))
    else $error("charging answered without query or on hsic");

endmodule // charger_detect_top

// ===== hdl/chgdet_pkg.sv
// constants, codes and register map shared by the charger-detect block
package chgdet_pkg;

  // timing
  localparam int SYS_CLK_MHZ = 200;
  localparam int SETTLE_NS   = 1000;
  localparam int SETTLE_CYC  = (SETTLE_NS * SYS_CLK_MHZ + 999) / 1000;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MASK_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] ISTS_OFS = 8'h0c;
  localparam logic [7:0] IMSK_OFS = 8'h10;
  localparam logic [7:0] MAN_OFS  = 8'h14;
  localparam logic [7:0] BCEN_OFS = 8'h18;

  // control field positions
  localparam int CTRL_DET_EN_BIT = 0;
  localparam int CTRL_ENH_BIT    = 1;
  localparam int CTRL_OSC_BIT    = 2;
  localparam int CTRL_SUP_BIT    = 3;
  localparam int CTRL_CHGSEL_BIT = 4;
  localparam int CTRL_EVTSEL_BIT = 5;
  localparam int CTRL_OUTEN_LSB  = 6;

  // manual driver field positions
  localparam int MAN_OVR_BIT    = 0;
  localparam int MAN_DPSRC_BIT  = 1;
  localparam int MAN_DMSRC_BIT  = 2;
  localparam int MAN_DMSINK_BIT = 3;

  // interrupt status bit positions
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_CHG_BIT  = 1;
  localparam int IRQ_SUSP_BIT = 2;
  localparam int IRQ_CFG_BIT  = 3;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'hf1;
  localparam logic [7:0] MASK_RST = 8'h7e;
  localparam logic [3:0] IMSK_RST = 4'h0;
  localparam logic [3:0] MAN_RST  = 4'h0;

  // charger type codes
  localparam logic [2:0] TYPE_NONE     = 3'h0;
  localparam logic [2:0] TYPE_DCP      = 3'h1;
  localparam logic [2:0] TYPE_CDP      = 3'h2;
  localparam logic [2:0] TYPE_SDP      = 3'h3;
  localparam logic [2:0] TYPE_PROP_LO  = 3'h4;
  localparam logic [2:0] TYPE_PROP_HI  = 3'h5;
  localparam logic [2:0] TYPE_PROP_SHI = 3'h6;

  // charger-detect output codes
  localparam logic [1:0] OUT_NONE = 2'h0;
  localparam logic [1:0] OUT_VBUS = 2'h1;
  localparam logic [1:0] OUT_CFG  = 2'h2;
  localparam logic [1:0] OUT_CHG  = 2'h3;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DET_IDLE   = 2'b00,
    DET_PROBE  = 2'b01,
    DET_SAMPLE = 2'b11,
    DET_DONE   = 2'b10
  } det_state_type;

endpackage

// ===== hdl/line_classifier.sv
// data-line comparator pattern to charger type code
`timescale 1ns/1ps
module line_classifier import chgdet_pkg::*; (
  input  wire logic       sys_clk,      // system clock
  input  wire logic       reset_n,      // sync reset, active low
  input  wire logic       line_short,   // lines shorted together
  input  wire logic       dm_reflect,   // dp level seen on dm
  input  wire logic       dp_low,       // dp held low by pull-down
  input  wire logic       dm_low,       // dm held low by pull-down
  input  wire logic       dp_2v0,       // dp in 2.0 v window
  input  wire logic       dp_2v7,       // dp in 2.7 v window
  input  wire logic       dm_2v0,       // dm in 2.0 v window
  input  wire logic       dm_2v7,       // dm in 2.7 v window
  input  wire logic       enhanced,     // enhanced detect enable
  output logic      [2:0] code_r        // classified type code
);

  typedef struct packed {
    logic [2:0] code;
  } cls_type;

  cls_type st_r;
  cls_type st_nxt;

  // proprietary voltage pairs win, they can also trip the simpler tests
  always_comb begin
    st_nxt = st_r;
    if (dp_2v7 && dm_2v0) begin
      st_nxt.code = TYPE_PROP_SHI;
    end else if (dp_2v0 && dm_2v0) begin
      st_nxt.code = TYPE_PROP_LO;
    end else if (dp_2v0 && dm_2v7) begin
      st_nxt.code = TYPE_PROP_HI;
    end else if (line_short) begin
      st_nxt.code = TYPE_DCP;
    end else if (dm_reflect && enhanced) begin
      st_nxt.code = TYPE_CDP;
    end else if (dp_low && dm_low) begin
      st_nxt.code = TYPE_SDP;
    end else begin
      st_nxt.code = TYPE_NONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign code_r = st_r.code;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_plain_short;
    line_short && !dp_2v0 && !dp_2v7;
  endsequence

  a_dcp_code: assert property (
    s_plain_short |=> code_r == TYPE_DCP)
    else $error("shorted lines not coded as dedicated port");
  a_cdp_code: assert property (
    dm_reflect && !line_short && !dp_2v0 && !dp_2v7 |=>
      code_r == ($past(enhanced) ? TYPE_CDP :
                 ($past(dp_low && dm_low) ? TYPE_SDP : TYPE_NONE)))
    else $error("reflected line coding wrong for enhanced setting");
  a_prop_code: assert property (
    dp_2v0 && dm_2v7 && !dp_2v7 && !dm_2v0 |=> code_r == TYPE_PROP_HI)
    else $error("high current pair not coded 101");

endmodule // line_classifier

// ===== tb/charger_model.sv
// upstream charger model that drives the data-line comparator levels
`timescale 1ns/1ps
module charger_model (
  input  wire logic       sys_clk,   // system clock
  input  wire logic [2:0] kind,      // attached charger kind
  input  wire logic       dp_src_en, // block sources the dp line
  output logic      [7:0] lines      // comparator levels to the block
);
  // reflection only shows while dp is sourced, as on a real port
  always_ff @(posedge sys_clk) begin
    case (kind)
      3'h1:    lines <= 8'h01;
      3'h2:    lines <= {6'h0, dp_src_en, 1'b0};
      3'h3:    lines <= 8'h0c;
      3'h4:    lines <= 8'h50;
      3'h5:    lines <= 8'h90;
      3'h6:    lines <= 8'h60;
      default: lines <= 8'h00;
    endcase
  end
endmodule // charger_model

// ===== tb/charger_detect_top_tb.sv
// self-checking bench for the charger-detect block
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("wrong value %s exp %h got %h", n, e, g); end end
module charger_detect_top_tb import chgdet_pkg::*;;
  logic        sys_clk, reset_n, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, lines, mask;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb, bc_query, downstream_hsic, bc_ack;
  logic [1:0]  s_axi_bresp, s_axi_rresp, charger_detect_out, resp;
  logic        detection_stage, clock_wait_stage, reference_clock_input;
  logic        upstream_hsic, vbus_present, device_suspended;
  logic        device_configured, dp_src_en, dm_src_en, dm_sink_en, irq;
  logic        downstream_supply_indicator;
  logic [2:0]  kind;
  int          check_count, miscompares, seed, exp_t;

  charger_model u_chg (.sys_clk, .kind, .dp_src_en, .lines);

  charger_detect_top #(.NUM_PORTS(4)) u_dut (
    .sys_clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .detection_stage, .clock_wait_stage,
    .reference_clock_input, .upstream_hsic, .vbus_present,
    .device_suspended, .device_configured, .line_short(lines[0]),
    .dm_reflect(lines[1]), .dp_low(lines[2]), .dm_low(lines[3]),
    .dp_2v0(lines[4]), .dp_2v7(lines[5]), .dm_2v0(lines[6]),
    .dm_2v7(lines[7]), .dp_src_en, .dm_src_en, .dm_sink_en,
    .charger_detect_out, .irq, .downstream_supply_indicator,
    .bc_query, .downstream_hsic, .bc_ack
  );

  // clock at 200 mhz
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // one write: each half released when taken, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // one read; data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // polls the state field; watchdog covers a run that never ends
  task automatic wait_done;
    repeat (5) @(posedge sys_clk);
    `CHK("dp_src", 1'b1, dp_src_en)
    `CHK("dm_sink", 1'b1, dm_sink_en)
    do rd(STAT_OFS); while (rd_data[5:4] !== 2'b10);
  endtask

  // one automatic run against the model's expected code
  task automatic run(input logic [2:0] k, input logic e,
                     input logic [7:0] m);
    kind <= k;
    wr(MASK_OFS, {24'h0, m});
    wr(IMSK_OFS, 32'h1);
    wr(ISTS_OFS, 32'hf);
    wr(CTRL_OFS, {24'h0, 6'h3c, e, 1'b1});
    `CHK("irq", 1'b0, irq)
    detection_stage <= 1'b1;
    wait_done();
    detection_stage <= 1'b0;
    exp_t = (k == 3'h2 && !e) ? 0 : int'(k);
    `CHK("type", exp_t[2:0], rd_data[2:0])
    `CHK("out", (m[exp_t] && exp_t != 0) ? 2'h3 : 2'h0,
         charger_detect_out)
    `CHK("irq", 1'b1, irq)
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, detection_stage, clock_wait_stage} = '0;
    {reference_clock_input, upstream_hsic, vbus_present} = '0;
    {device_suspended, device_configured, bc_query} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, downstream_hsic} = '0;
    s_axi_wstrb = 4'hf;
    kind = 3'h0;
    seed = 32'h2ea52eb0;
    reset_n = 1'b0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    `CHK("out", 2'h0, charger_detect_out)
    `CHK("irq", 1'b0, irq)
    rd(CTRL_OFS);
    `CHK("ctrl", 32'hf1, rd_data)
    rd(MASK_OFS);
    `CHK("mask", 32'h7e, rd_data)
    rd(8'h40);
    `CHK("rresp", RESP_SLVERR, resp)
    // every kind with both detection settings and random masks
    for (int i = 0; i < 14; i++) begin
      mask = 8'($random(seed));
      run(3'(i % 7), 1'(i / 7), mask & 8'hfe);
    end
    // hsic upstream keeps the detector idle
    upstream_hsic <= 1'b1;
    kind <= 3'h1;
    detection_stage <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rd(STAT_OFS);
    `CHK("state", 2'b00, rd_data[5:4])
    detection_stage <= 1'b0;
    upstream_hsic <= 1'b0;
    // reference_clock_input never toggles: only the oscillator fallback may start
    clock_wait_stage <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rd(STAT_OFS);
    `CHK("state", 2'b00, rd_data[5:4])
    wr(CTRL_OFS, 32'hf5);
    wait_done();
    `CHK("type", 3'h1, rd_data[2:0])
    clock_wait_stage <= 1'b0;
    // reference_clock_input now alive, oscillator fallback off
    wr(CTRL_OFS, 32'hf1);
    reference_clock_input <= 1'b1;
    clock_wait_stage <= 1'b1;
    wait_done();
    `CHK("type", 3'h1, rd_data[2:0])
    clock_wait_stage <= 1'b0;
    // direct driver control while the hub sits in no stage
    wr(MAN_OFS, 32'h3);
    `CHK("dp_src", 1'b1, dp_src_en)
    `CHK("dm_src", 1'b0, dm_src_en)
    wr(MAN_OFS, 32'hd);
    `CHK("dm_src", 1'b1, dm_src_en)
    `CHK("dp_src", 1'b0, dp_src_en)
    wr(MAN_OFS, 32'h0);
    // device events on the output, then one bit enabled alone
    vbus_present <= 1'b1;
    device_configured <= 1'b1;
    wr(CTRL_OFS, 32'he9);
    repeat (3) @(posedge sys_clk);
    `CHK("out", 2'h2, charger_detect_out)
    `CHK("supply", 1'b1, downstream_supply_indicator)
    device_suspended <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("out", 2'h1, charger_detect_out)
    wr(CTRL_OFS, 32'ha9);
    repeat (3) @(posedge sys_clk);
    `CHK("out", 2'h0, charger_detect_out)
    device_suspended <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK("out", 2'h2, charger_detect_out)
    // every event kind has fired by now; write one to clear
    rd(ISTS_OFS);
    `CHK("ists", 32'hf, rd_data)
    wr(ISTS_OFS, 32'hf);
    rd(ISTS_OFS);
    `CHK("ists", 32'h0, rd_data)
    // charging queries answered on enabled non-hsic ports only
    wr(BCEN_OFS, 32'h7);
    repeat (8) begin
      bc_query <= 4'($random(seed));
      downstream_hsic <= 4'($random(seed));
      repeat (2) @(posedge sys_clk);
      `CHK("bc_ack", bc_query & ~downstream_hsic & 4'h7, bc_ack)
    end
    wr(8'h40, 32'h1);
    `CHK("bresp", RESP_SLVERR, resp)
    final_report();
  end

  // cuts a hang short
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
endmodule // charger_detect_top_tb
